// File: include/ict_pkg.sv
// Constants shared by the interval counter/timer design
// Functional notes
// - Three independent 32-bit binary down-counters
// - Each counter has its own mode 0..5
// - Mode 0 output low after programming
// - Mode 0 output stays high until rewritten
// - Mode 1 is mode 0 with gate trigger
// - Mode 2 pulses low one clock, reloads, repeats
// - Mode 2 raises a periodic interrupt event
// - Modes 2 and 3 period is reload plus two
// - Mode 3 high first half, low rest
// - Mode 4 strobes low one clock at expiry
// - Mode 4 started by writing the count
// - Mode 4 new count loads next clock
// - Mode 5 is mode 4 with gate trigger
// - Latch command freezes count; status readable
// - Gate, external clock and output polarity selectable
// - Hardware or software gate, gate readable
// - Per-counter interrupt enable and status register
// - Clock is bus clock/4, oscillator, or external pin on counters 1 and 2
// - Expiry signals an interrupt to the host
package ict_pkg;
	localparam int NUM_CH = 3;
	// Register byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_LATCH = 8'h04;
	localparam logic [7:0] REG_IRQ = 8'h08;
	localparam logic [7:0] REG_CFG0 = 8'h10;
	localparam logic [7:0] REG_RELOAD0 = 8'h20;
	localparam logic [7:0] REG_COUNT0 = 8'h30;
	localparam logic [7:0] REG_STATUS0 = 8'h40;
	// Control register field
	localparam int CTRL_CLK_SEL = 0;
	// Per-counter configuration fields, mode in bits 2:0
	localparam int CFG_W = 10;
	localparam int CFG_SWSEL = 3;
	localparam int CFG_SWGATE = 4;
	localparam int CFG_INV_GATE = 5;
	localparam int CFG_INV_CLK = 6;
	localparam int CFG_INV_OUT = 7;
	localparam int CFG_EXT_CLK = 8;
	localparam int CFG_IRQ_EN = 9;
	// Status register fields, mode in bits 2:0
	localparam int ST_OUT = 3;
	localparam int ST_GATE = 4;
	localparam int ST_LOAD = 5;
	localparam int ST_ARMED = 6;
	localparam int ST_WRAP = 7;
	// Operating modes
	localparam logic [2:0] MODE_TC = 3'h0;
	localparam logic [2:0] MODE_ONESHOT = 3'h1;
	localparam logic [2:0] MODE_RATE = 3'h2;
	localparam logic [2:0] MODE_SQUARE = 3'h3;
	localparam logic [2:0] MODE_SWSTROBE = 3'h4;
	localparam logic [2:0] MODE_HWSTROBE = 3'h5;
	// Bus clock divided by four: tick on the last of four cycles
	localparam logic [1:0] BUS_DIV_LAST = 2'h3;
	// Values after reset
	localparam logic [CFG_W-1:0] CFG_RST = 10'h000;
	localparam logic [31:0] RELOAD_RST = 32'h00000000;
endpackage

// File: src/ict_sync.sv
// Two-stage synchroniser with polarity select and rising-edge detect
module ict_sync (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Pin and polarity
	input wire logic pin_in,
	input wire logic inv,
	// Synchronised results
	output logic level,
	output logic rise
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} ict_sync_t;

	ict_sync_t s;
	ict_sync_t next_s;

	// First stage feeds only the second stage
	always_comb begin
		next_s = s;
		next_s.s1 = pin_in;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Inversion applied before edge detect so the active edge follows polarity
	assign level = s.s2 ^ inv;
	assign rise = (s.s2 ^ inv) & ~(s.s3 ^ inv);
endmodule // ict_sync

// File: src/ict_top.sv
// Three-channel programmable interval counter/timer with register port
module ict_top (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// Clock sources
	input wire logic osc_10mhz_in,
	input wire logic timer1_ext_clock_in,
	input wire logic timer2_ext_clock_in,
	// Gate inputs
	input wire logic timer0_gate_in,
	input wire logic timer1_gate_in,
	input wire logic timer2_gate_in,
	// Field outputs and interrupt
	output logic timer0_output,
	output logic timer1_output,
	output logic timer2_output,
	output logic irq
);
	typedef struct packed {
		logic [1:0] div;
		logic clk_sel;
		logic [2:0][ict_pkg::CFG_W-1:0] cfg;
		logic [2:0][31:0] reload;
		logic [2:0][31:0] count;
		logic [2:0][31:0] latched;
		logic [2:0] lat_hold;
		logic [2:0] load_pend;
		logic [2:0] trig_pend;
		logic [2:0] armed;
		logic [2:0] wrap;
		logic [2:0] out;
		logic [2:0] gprev;
		logic [2:0] pend;
		logic [2:0] pin;
		logic irq;
		logic [31:0] rdata;
	} ict_state_t;

	ict_state_t s;
	ict_state_t next_s;

	logic bus_tick;
	logic osc_rise;
	logic timer0_internal_clock;
	logic [2:0] gate_in;
	logic [2:0] hw_gate;
	logic [2:0] gate;
	logic [2:0] trig;
	logic [2:0] ext_rise;
	logic [2:0] tick;
	logic [2:0] hw_mode;
	logic [2:0][2:0] mode;
	logic [2:0] ev;
	logic [2:0] clr;
	logic [1:0] idx;
	logic idx_ok;

	assign gate_in = {timer2_gate_in, timer1_gate_in, timer0_gate_in};
	assign idx = addr[3:2];
	assign idx_ok = (idx != 2'h3) && (addr[1:0] == 2'h0);

	// Bus clock divided by four, or the oscillator edge
	assign bus_tick = (s.div == ict_pkg::BUS_DIV_LAST);
	assign timer0_internal_clock = s.clk_sel ? osc_rise : bus_tick;

	// Oscillator is asynchronous to the bus clock; sampled, so it must stay below clk_sys/4
	ict_sync u_osc (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.pin_in(osc_10mhz_in),
		.inv(1'b0),
		.level(),
		.rise(osc_rise)
	);

	// External clocks exist only for counters 1 and 2
	assign ext_rise[0] = 1'b0;
	ict_sync u_clk1 (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.pin_in(timer1_ext_clock_in),
		.inv(s.cfg[1][ict_pkg::CFG_INV_CLK]),
		.level(),
		.rise(ext_rise[1])
	);
	ict_sync u_clk2 (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.pin_in(timer2_ext_clock_in),
		.inv(s.cfg[2][ict_pkg::CFG_INV_CLK]),
		.level(),
		.rise(ext_rise[2])
	);

	// Per-channel gate selection, trigger edge and clock selection
	for (genvar g = 0; g < ict_pkg::NUM_CH; g++) begin : g_ch
		ict_sync u_gate (
			.clk_sys(clk_sys),
			.rstn(rstn),
			.pin_in(gate_in[g]),
			.inv(s.cfg[g][ict_pkg::CFG_INV_GATE]),
			.level(hw_gate[g]),
			.rise()
		);
		assign gate[g] = s.cfg[g][ict_pkg::CFG_SWSEL] ? s.cfg[g][ict_pkg::CFG_SWGATE] : hw_gate[g];
		assign trig[g] = gate[g] & ~s.gprev[g];
		assign mode[g] = s.cfg[g][2:0];
		assign hw_mode[g] = (mode[g] == ict_pkg::MODE_ONESHOT) || (mode[g] == ict_pkg::MODE_HWSTROBE);
		assign tick[g] = (g != 0 && s.cfg[g][ict_pkg::CFG_EXT_CLK]) ? ext_rise[g] : timer0_internal_clock;
	end

	// Whole next state: counters first, then register writes, then reads
	always_comb begin
		next_s = s;
		ev = 3'h0;
		clr = 3'h0;
		next_s.div = s.div + 2'h1;
		next_s.rdata = 32'h0;
		for (int i = 0; i < ict_pkg::NUM_CH; i++) begin
			next_s.gprev[i] = gate[i];
			// Trigger edge held until the next counting clock so slow clocks miss none
			if (trig[i]) begin
				next_s.trig_pend[i] = 1'b1;
			end
			if (tick[i]) begin
				if (hw_mode[i] ? s.trig_pend[i] : s.load_pend[i]) begin
					// Start or restart from the reload value
					next_s.count[i] = s.reload[i];
					next_s.armed[i] = 1'b1;
					next_s.load_pend[i] = 1'b0;
					next_s.trig_pend[i] = trig[i];
					next_s.wrap[i] = 1'b0;
					next_s.out[i] = (mode[i] != ict_pkg::MODE_TC) && (mode[i] != ict_pkg::MODE_ONESHOT);
				end else if (s.armed[i] && (hw_mode[i] || gate[i])) begin
					case (mode[i])
						ict_pkg::MODE_TC, ict_pkg::MODE_ONESHOT: begin
							if (s.count[i] <= 32'h00000001) begin
								next_s.count[i] = 32'h00000000;
								next_s.out[i] = 1'b1;
								next_s.armed[i] = 1'b0;
								ev[i] = 1'b1;
							end else begin
								next_s.count[i] = s.count[i] - 32'h00000001;
							end
						end
						ict_pkg::MODE_RATE: begin
							// N ticks down to zero, one low tick, one reload tick
							if (s.wrap[i]) begin
								next_s.out[i] = 1'b1;
								next_s.count[i] = s.reload[i];
								next_s.wrap[i] = 1'b0;
							end else if (s.count[i] == 32'h00000000) begin
								next_s.out[i] = 1'b0;
								next_s.wrap[i] = 1'b1;
								ev[i] = 1'b1;
							end else begin
								next_s.count[i] = s.count[i] - 32'h00000001;
							end
						end
						ict_pkg::MODE_SQUARE: begin
							if (s.wrap[i]) begin
								next_s.out[i] = 1'b1;
								next_s.count[i] = s.reload[i];
								next_s.wrap[i] = 1'b0;
								ev[i] = 1'b1;
							end else if (s.count[i] == 32'h00000000) begin
								next_s.wrap[i] = 1'b1;
							end else begin
								next_s.count[i] = s.count[i] - 32'h00000001;
								// Low once the remaining count drops to half the reload
								next_s.out[i] = (s.count[i] - 32'h00000001) > (s.reload[i] >> 1);
							end
						end
						ict_pkg::MODE_SWSTROBE, ict_pkg::MODE_HWSTROBE: begin
							if (s.wrap[i]) begin
								next_s.out[i] = 1'b1;
								next_s.wrap[i] = 1'b0;
								next_s.armed[i] = 1'b0;
							end else if (s.count[i] == 32'h00000000) begin
								next_s.out[i] = 1'b0;
								next_s.wrap[i] = 1'b1;
								ev[i] = 1'b1;
							end else begin
								next_s.count[i] = s.count[i] - 32'h00000001;
							end
						end
						default: begin
							// Undefined modes 6 and 7 hold the counter still
							next_s.armed[i] = 1'b0;
						end
					endcase
				end
			end
			// Register writes for this channel override the counting step
			if (wr && idx_ok && idx == 2'(i)) begin
				if (addr[7:4] == ict_pkg::REG_CFG0[7:4]) begin
					next_s.cfg[i] = wdata[ict_pkg::CFG_W-1:0];
					next_s.armed[i] = 1'b0;
					next_s.load_pend[i] = 1'b0;
					next_s.trig_pend[i] = 1'b0;
					next_s.wrap[i] = 1'b0;
					next_s.out[i] = (wdata[2:0] != ict_pkg::MODE_TC);
				end
				if (addr[7:4] == ict_pkg::REG_RELOAD0[7:4]) begin
					next_s.reload[i] = wdata;
					next_s.wrap[i] = 1'b0;
					// Triggered modes wait for the gate edge instead
					next_s.load_pend[i] = !hw_mode[i];
					if (mode[i] == ict_pkg::MODE_TC) begin
						next_s.out[i] = 1'b0;
						next_s.armed[i] = 1'b0;
					end
				end
			end
			// Latch command freezes the count until it is read
			if (wr && addr == ict_pkg::REG_LATCH && wdata[i]) begin
				next_s.latched[i] = s.count[i];
				next_s.lat_hold[i] = 1'b1;
			end
			if (rd && idx_ok && idx == 2'(i) && addr[7:4] == ict_pkg::REG_COUNT0[7:4]) begin
				next_s.lat_hold[i] = 1'b0;
			end
		end
		if (wr && addr == ict_pkg::REG_CTRL) begin
			next_s.clk_sel = wdata[ict_pkg::CTRL_CLK_SEL];
		end
		// Write one to clear; a new event in the same cycle wins
		if (wr && addr == ict_pkg::REG_IRQ) begin
			clr = wdata[2:0];
		end
		next_s.pend = (s.pend & ~clr) | ev;
		next_s.irq = 1'b0;
		for (int i = 0; i < ict_pkg::NUM_CH; i++) begin
			next_s.irq = next_s.irq | (next_s.pend[i] & next_s.cfg[i][ict_pkg::CFG_IRQ_EN]);
			next_s.pin[i] = next_s.out[i] ^ next_s.cfg[i][ict_pkg::CFG_INV_OUT];
		end
		// Read data stands in the cycle after the strobe; unmapped reads give zero
		if (rd) begin
			if (addr == ict_pkg::REG_CTRL) begin
				next_s.rdata = {31'h0, s.clk_sel};
			end else if (addr == ict_pkg::REG_IRQ) begin
				next_s.rdata = {29'h0, s.pend};
			end else if (idx_ok) begin
				case (addr[7:4])
					ict_pkg::REG_CFG0[7:4]: next_s.rdata = {22'h0, s.cfg[idx]};
					ict_pkg::REG_RELOAD0[7:4]: next_s.rdata = s.reload[idx];
					ict_pkg::REG_COUNT0[7:4]: next_s.rdata = s.lat_hold[idx] ? s.latched[idx] : s.count[idx];
					ict_pkg::REG_STATUS0[7:4]: begin
						next_s.rdata[2:0] = mode[idx];
						next_s.rdata[ict_pkg::ST_OUT] = s.out[idx];
						next_s.rdata[ict_pkg::ST_GATE] = gate[idx];
						next_s.rdata[ict_pkg::ST_LOAD] = s.load_pend[idx];
						next_s.rdata[ict_pkg::ST_ARMED] = s.armed[idx];
						next_s.rdata[ict_pkg::ST_WRAP] = s.wrap[idx];
					end
					default: next_s.rdata = 32'h0;
				endcase
			end
		end
	end

	// Single state register; zero is mode 0, software gate off, outputs low
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign rdata = s.rdata;
	assign timer0_output = s.pin[0];
	assign timer1_output = s.pin[1];
	assign timer2_output = s.pin[2];
	assign irq = s.irq;

	// Checks on channel 0, the channel 1 event flag and the shared logic
	a_mode0_write_low: assert property (@(posedge clk_sys) disable iff (!rstn)
		(wr && addr == ict_pkg::REG_RELOAD0 && mode[0] == ict_pkg::MODE_TC) |=> !s.out[0] ##1 !timer0_output
			|| s.cfg[0][ict_pkg::CFG_INV_OUT])
		else $error("mode 0 output not low after count write");
	a_mode0_hold_high: assert property (@(posedge clk_sys) disable iff (!rstn)
		(mode[0] == ict_pkg::MODE_TC && s.out[0] && !(wr && addr == ict_pkg::REG_RELOAD0)
			&& !(wr && addr == ict_pkg::REG_CFG0)) |=> s.out[0])
		else $error("mode 0 output fell without a new count");
	a_rate_low_one: assert property (@(posedge clk_sys) disable iff (!rstn)
		(mode[0] == ict_pkg::MODE_RATE && !s.out[0] && s.armed[0] && tick[0] && gate[0] && !wr)
			|=> s.out[0])
		else $error("mode 2 low pulse longer than one clock");
	a_rate_event: assert property (@(posedge clk_sys) disable iff (!rstn)
		(mode[0] == ict_pkg::MODE_RATE && s.armed[0] && !s.load_pend[0] && tick[0] && gate[0]
			&& !s.wrap[0] && s.count[0] == 32'h0 && !wr) |=> s.pend[0] && !s.out[0])
		else $error("mode 2 cycle end raised no event");
	a_event_sticks: assert property (@(posedge clk_sys) disable iff (!rstn)
		ev[1] |=> s.pend[1])
		else $error("event lost against clear");
	a_irq_follows: assert property (@(posedge clk_sys) disable iff (!rstn)
		(ev[0] && s.cfg[0][ict_pkg::CFG_IRQ_EN] && !(wr && addr == ict_pkg::REG_CFG0)) |=> irq)
		else $error("enabled expiry gave no interrupt");
	a_count_dec: assert property (@(posedge clk_sys) disable iff (!rstn)
		(mode[0] == ict_pkg::MODE_TC && s.armed[0] && !s.load_pend[0] && tick[0] && gate[0]
			&& s.count[0] > 32'h1 && !wr) |=> s.count[0] == $past(s.count[0]) - 32'h1)
		else $error("count did not drop by one");
	a_bus_div4: assert property (@(posedge clk_sys) disable iff (!rstn)
		bus_tick |=> (!bus_tick) [*3] ##1 bus_tick)
		else $error("bus clock divider not by four");
	// Any channel: a held latch is what a count read returns, not the live count
	a_latch_read: assert property (@(posedge clk_sys) disable iff (!rstn)
		(rd && idx_ok && addr[7:4] == ict_pkg::REG_COUNT0[7:4] && s.lat_hold[idx])
			|=> rdata == $past(s.latched[idx]))
		else $error("latched count not returned");
	a_wrap_reload: assert property (@(posedge clk_sys) disable iff (!rstn)
		(mode[0] == ict_pkg::MODE_RATE && s.armed[0] && !s.load_pend[0] && s.wrap[0] && tick[0] && gate[0] && !wr)
			|=> s.count[0] == $past(s.reload[0]) && !s.wrap[0])
		else $error("mode 2 did not reload after the low tick");
	// Gate as trigger: the edge is kept, then starts the count whatever the level
	a_trig_held: assert property (@(posedge clk_sys) disable iff (!rstn)
		(trig[0] && !wr) |=> s.trig_pend[0])
		else $error("gate edge not kept for the next clock");
	a_oneshot_load: assert property (@(posedge clk_sys) disable iff (!rstn)
		(mode[0] == ict_pkg::MODE_ONESHOT && s.trig_pend[0] && tick[0] && !wr)
			|=> s.count[0] == $past(s.reload[0]) && s.armed[0] && !s.out[0])
		else $error("mode 1 trigger did not start the count");
	a_irq_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
		(wr && addr == ict_pkg::REG_IRQ && wdata[0] && !ev[0]) |=> !s.pend[0])
		else $error("pending flag not cleared by write");
	a_mode_indep: assert property (@(posedge clk_sys) disable iff (!rstn)
		(wr && addr == ict_pkg::REG_CFG0) |=> s.cfg[1] == $past(s.cfg[1]) && s.cfg[2] == $past(s.cfg[2]))
		else $error("mode write reached another counter");
	// Checks on channel 2, the one run software-gated and as a software strobe
	a_strobe_reload: assert property (@(posedge clk_sys) disable iff (!rstn)
		(mode[2] == ict_pkg::MODE_SWSTROBE && s.load_pend[2] && tick[2] && !wr)
			|=> s.count[2] == $past(s.reload[2]) && s.armed[2])
		else $error("mode 4 count not loaded on next clock");
	a_strobe_low_one: assert property (@(posedge clk_sys) disable iff (!rstn)
		(mode[2] == ict_pkg::MODE_SWSTROBE && !s.out[2] && tick[2] && gate[2] && !wr) |=> s.out[2])
		else $error("mode 4 strobe longer than one clock");
	a_swgate_pause: assert property (@(posedge clk_sys) disable iff (!rstn)
		(s.cfg[2][ict_pkg::CFG_SWSEL] && !s.cfg[2][ict_pkg::CFG_SWGATE] && !hw_mode[2]
			&& !s.load_pend[2] && !wr) |=> s.count[2] == $past(s.count[2]))
		else $error("count moved with the software gate off");
endmodule // ict_top

// File: verif/ict_field_model.sv
// Behavioural far side: oscillator, external counting clocks and gate lines
module ict_field_model (
	// Bench controls
	input wire logic ext_run,
	input wire logic [2:0] gate_cmd,
	// Field lines
	output logic osc_10mhz_in,
	output logic timer1_ext_clock_in,
	output logic timer2_ext_clock_in,
	output logic [2:0] gate
);
	timeunit 1ns;
	timeprecision 100ps;
	// Oscillator runs free; the offset keeps its edges off the system clock edges
	initial begin
		osc_10mhz_in = 1'b0;
		#7;
		forever #50 osc_10mhz_in = ~osc_10mhz_in;
	end
	// External clocks run only while asked and stand low otherwise
	initial begin
		timer1_ext_clock_in = 1'b0;
		timer2_ext_clock_in = 1'b0;
		#3;
		forever begin
			#70;
			timer1_ext_clock_in = ext_run & ~timer1_ext_clock_in;
			timer2_ext_clock_in = timer1_ext_clock_in;
		end
	end
	// Gate lines lag the command like a slow field driver
	assign #3 gate = gate_cmd;
endmodule // ict_field_model

// File: verif/interval_counter_timer_tb.sv
// Self-checking bench for the three-channel counter/timer
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; $display("CHECK FAILED t=%0t got %0h", $time, a); end end
module interval_counter_timer_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys, rstn, wr, rd, ext_run, osc, ck1, ck2, irq;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, d, v1;
	logic [2:0] gate_cmd, gate, m;
	wire [2:0] outs;
	int fails, tests_run, cyc, wt, t0, t1, lo, per, n, ch;
	ict_top dut (.clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.osc_10mhz_in(osc), .timer1_ext_clock_in(ck1), .timer2_ext_clock_in(ck2), .timer0_gate_in(gate[0]),
		.timer1_gate_in(gate[1]), .timer2_gate_in(gate[2]), .timer0_output(outs[0]),
		.timer1_output(outs[1]), .timer2_output(outs[2]), .irq(irq));
	ict_field_model field (.ext_run(ext_run), .gate_cmd(gate_cmd), .osc_10mhz_in(osc),
		.timer1_ext_clock_in(ck1), .timer2_ext_clock_in(ck2), .gate(gate));
	// System clock and a cycle count used to time output edges
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) cyc <= cyc + 1;
	// Waits past edges so design updates have landed before sampling
	task automatic tick(input int k);
		repeat (k) begin
			@(posedge clk_sys);
			#1;
		end
	endtask
	// Bus write; wt holds the cycle count of the edge that takes it
	task automatic bw(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
		#1 wt = cyc;
	endtask
	// Bus read; data stand only in the cycle after the strobe
	task automatic br(input logic [7:0] a);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic cfg(input int c, input logic [31:0] v);
		bw(ict_pkg::REG_CFG0 + 8'(4 * c), v);
	endtask
	task automatic gset(input logic [2:0] v);
		@(posedge clk_sys);
		gate_cmd <= v;
	endtask
	// Bounded wait for an output level; t is the cycle it was seen
	task automatic wl(input int c, input logic lv, input int lim, output int t);
		int k;
		k = 0;
		while (outs[c] !== lv && k < lim) begin
			tick(1);
			k++;
		end
		if (k >= lim) begin
			fails++;
			$display("CHECK FAILED t=%0t output wait", $time);
		end
		t = cyc;
	endtask
	// Counts cycles in which an output leaves the level it should hold
	task automatic hold(input int c, input logic lv, input int k, output int bad);
		bad = 0;
		repeat (k) begin
			tick(1);
			if (outs[c] !== lv) bad++;
		end
	endtask
	// Pulse width and period of a periodic output, p is the pulse level
	task automatic meas(input int c, input logic p);
		int ta;
		wl(c, p, 400, ta);
		wl(c, !p, 100, t1);
		wl(c, p, 400, t0);
		lo = t1 - ta;
		per = t0 - ta;
	endtask
	function automatic int per_exp(input int nn, input int dv);
		return (nn + 2) * dv;
	endfunction
	function automatic logic in_rng(input int v, input int l, input int h);
		return v >= l && v <= h;
	endfunction
	task automatic stop_test;
		$display("Mismatches %0d, comparisons %0d", fails, tests_run);
		if (fails == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Watchdog sized well past the thousand or so cycles the sequence needs
	initial begin
		#1000000;
		fails++;
		$display("CHECK FAILED t=%0t watchdog", $time);
		stop_test();
	end
	// Main sequence
	initial begin
		rstn = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h00000000;
		gate_cmd = 3'h7;
		ext_run = 1'b0;
		void'($urandom(94069));
		repeat (10) @(posedge clk_sys);
		rstn <= 1'b1;
		tick(1);
		`CHK(outs, 3'h0)
		br(ict_pkg::REG_RELOAD0);
		`CHK(d, ict_pkg::RELOAD_RST)
		bw(8'hFC, 32'hFFFFFFFF);
		br(8'hFC);
		`CHK(d, 32'h00000000)
		br(ict_pkg::REG_CFG0 + 8'h0C);
		`CHK(d, 32'h00000000)
		for (int i = 0; i < 6; i++) begin
			cfg(i % 3, 32'(i));
			br(ict_pkg::REG_STATUS0 + 8'(4 * (i % 3)));
			`CHK(d[2:0], 3'(i))
		end
		for (int i = 0; i < 3; i++) begin
			br(ict_pkg::REG_STATUS0 + 8'(4 * i));
			`CHK(d[2:0], 3'(i + 3))
		end
		// Terminal count with the gate pin low but inverted, interrupt enabled
		gset(3'b110);
		cfg(0, (1 << ict_pkg::CFG_INV_GATE) | (1 << ict_pkg::CFG_IRQ_EN));
		bw(ict_pkg::REG_RELOAD0, 32'h00000007);
		tick(2);
		`CHK(outs[0], 1'b0)
		wl(0, 1'b1, 80, t0);
		`CHK(in_rng(t0 - wt, 29, 36), 1'b1)
		tick(2);
		`CHK(irq, 1'b1)
		br(ict_pkg::REG_IRQ);
		`CHK(d[2:0], 3'b001)
		hold(0, 1'b1, 40, n);
		`CHK(n, 0)
		bw(ict_pkg::REG_IRQ, 32'h00000001);
		tick(2);
		`CHK(irq, 1'b0)
		bw(ict_pkg::REG_RELOAD0, 32'h00000007);
		tick(2);
		`CHK(outs[0], 1'b0)
		// Software gate, latch and status on channel two; its pin is held low
		gset(3'b000);
		cfg(2, (1 << ict_pkg::CFG_SWSEL) | (1 << ict_pkg::CFG_SWGATE));
		bw(ict_pkg::REG_RELOAD0 + 8'h08, 32'd2000);
		tick(20);
		bw(ict_pkg::REG_LATCH, 32'h00000004);
		tick(40);
		br(ict_pkg::REG_COUNT0 + 8'h08);
		v1 = d;
		br(ict_pkg::REG_COUNT0 + 8'h08);
		`CHK(in_rng(int'(v1 - d), 9, 12), 1'b1)
		br(ict_pkg::REG_STATUS0 + 8'h08);
		`CHK(d[ict_pkg::ST_GATE], 1'b1)
		`CHK(d[2:0], ict_pkg::MODE_TC)
		cfg(2, 1 << ict_pkg::CFG_SWSEL);
		br(ict_pkg::REG_STATUS0 + 8'h08);
		`CHK(d[ict_pkg::ST_GATE], 1'b0)
		// Gate off: the new count loads but must not move
		bw(ict_pkg::REG_RELOAD0 + 8'h08, 32'd2000);
		tick(20);
		br(ict_pkg::REG_COUNT0 + 8'h08);
		v1 = d;
		`CHK(v1, 32'd2000)
		tick(40);
		br(ict_pkg::REG_COUNT0 + 8'h08);
		`CHK(d, v1)
		// Gate-triggered one-shot, then gate-triggered strobe
		cfg(0, 32'(ict_pkg::MODE_ONESHOT));
		bw(ict_pkg::REG_RELOAD0, 32'h00000005);
		hold(0, 1'b1, 40, n);
		`CHK(n, 0)
		gset(3'b001);
		wl(0, 1'b0, 20, t0);
		wl(0, 1'b1, 40, t1);
		`CHK(t1 - t0, 20)
		gset(3'b000);
		cfg(0, 32'(ict_pkg::MODE_HWSTROBE));
		bw(ict_pkg::REG_RELOAD0, 32'h00000003);
		hold(0, 1'b1, 40, n);
		`CHK(n, 0)
		gset(3'b001);
		wl(0, 1'b0, 40, t0);
		wl(0, 1'b1, 10, t1);
		`CHK(t1 - t0, 4)
		hold(0, 1'b1, 60, n);
		`CHK(n, 0)
		// Software strobe with interrupt disabled, then a rewrite in mid-count
		gset(3'b111);
		cfg(2, 32'(ict_pkg::MODE_SWSTROBE));
		bw(ict_pkg::REG_RELOAD0 + 8'h08, 32'h00000006);
		`CHK(outs[2], 1'b1)
		wl(2, 1'b0, 60, t0);
		`CHK(in_rng(t0 - wt, 25, 32), 1'b1)
		wl(2, 1'b1, 10, t1);
		`CHK(t1 - t0, 4)
		hold(2, 1'b1, 60, n);
		`CHK(n, 0)
		`CHK(irq, 1'b0)
		br(ict_pkg::REG_IRQ);
		`CHK(d[2], 1'b1)
		bw(ict_pkg::REG_IRQ, 32'h00000007);
		bw(ict_pkg::REG_RELOAD0 + 8'h08, 32'h00000006);
		tick(12);
		bw(ict_pkg::REG_RELOAD0 + 8'h08, 32'h00000006);
		wl(2, 1'b0, 60, t0);
		`CHK(in_rng(t0 - wt, 25, 32), 1'b1)
		// Inverted rate output, then external and oscillator clocks
		cfg(1, ict_pkg::MODE_RATE | (1 << ict_pkg::CFG_INV_OUT));
		tick(2);
		`CHK(outs[1], 1'b0)
		bw(ict_pkg::REG_RELOAD0 + 8'h04, 32'h00000004);
		meas(1, 1'b1);
		`CHK(lo, 4)
		@(posedge clk_sys);
		ext_run <= 1'b1;
		cfg(1, ict_pkg::MODE_RATE | (1 << ict_pkg::CFG_EXT_CLK));
		bw(ict_pkg::REG_RELOAD0 + 8'h04, 32'h00000003);
		meas(1, 1'b0);
		`CHK(per, per_exp(3, 7))
		bw(ict_pkg::REG_CTRL, 32'h00000001);
		cfg(0, 32'(ict_pkg::MODE_RATE));
		bw(ict_pkg::REG_RELOAD0, 32'h00000003);
		meas(0, 1'b0);
		`CHK(per, per_exp(3, 5))
		bw(ict_pkg::REG_CTRL, 32'h00000000);
		// Random rate and square-wave runs; the first is the shortest reload
		for (int i = 0; i < 5; i++) begin
			ch = (i == 0) ? 0 : int'($urandom % 3);
			n = (i == 0) ? 1 : 1 + int'($urandom % 10);
			m = ($urandom % 2) ? ict_pkg::MODE_SQUARE : ict_pkg::MODE_RATE;
			cfg(ch, 32'(m) | (1 << ict_pkg::CFG_IRQ_EN));
			bw(ict_pkg::REG_IRQ, 32'h00000007);
			bw(ict_pkg::REG_RELOAD0 + 8'(4 * ch), 32'(n));
			meas(ch, 1'b0);
			`CHK(per, per_exp(n, 4))
			// Square output stays low from half count through the zero and reload ticks
			`CHK(lo, (m == ict_pkg::MODE_RATE) ? 4 : (n / 2 + 2) * 4)
			br(ict_pkg::REG_IRQ);
			`CHK(d[ch], 1'b1)
			bw(ict_pkg::REG_IRQ, 32'h00000007);
		end
		stop_test();
	end
endmodule // interval_counter_timer_tb
